// ### include/axcf_if.sv
// Interface carrying the five AXI4 channels between master and slave.
`timescale 1ns/100ps
`default_nettype none
interface axcf_if
  import axcf_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RSTN
);
  logic [ID_W-1:0] awid;
  logic [ADDR_W-1:0] awaddr;
  logic [LEN_W-1:0] awlen;
  logic [2:0] awsize;
  logic [1:0] awburst;
  logic awlock;
  logic [3:0] awcache;
  logic [2:0] awprot;
  logic [3:0] awqos;
  logic [3:0] awregion;
  logic awvalid;
  logic awready;
  logic [DATA_W-1:0] wdata;
  logic [STRB_W-1:0] wstrb;
  logic wlast;
  logic wvalid;
  logic wready;
  logic [ID_W-1:0] bid;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [ID_W-1:0] arid;
  logic [ADDR_W-1:0] araddr;
  logic [LEN_W-1:0] arlen;
  logic [2:0] arsize;
  logic [1:0] arburst;
  logic arlock;
  logic [3:0] arcache;
  logic [2:0] arprot;
  logic [3:0] arqos;
  logic [3:0] arregion;
  logic arvalid;
  logic arready;
  logic [ID_W-1:0] rid;
  logic [DATA_W-1:0] rdata;
  logic [1:0] rresp;
  logic rlast;
  logic rvalid;
  logic rready;

  modport mst (
    input SYS_CLK, RSTN,
    output awid, awaddr, awlen, awsize, awburst, awlock, awcache, awprot, awqos, awregion,
    output awvalid, wdata, wstrb, wlast, wvalid, bready,
    output arid, araddr, arlen, arsize, arburst, arlock, arcache, arprot, arqos, arregion,
    output arvalid, rready,
    input awready, wready, bid, bresp, bvalid, arready, rid, rdata, rresp, rlast, rvalid
  );

  modport slv (
    input SYS_CLK, RSTN,
    input awid, awaddr, awlen, awsize, awburst, awlock, awcache, awprot, awqos, awregion,
    input awvalid, wdata, wstrb, wlast, wvalid, bready,
    input arid, araddr, arlen, arsize, arburst, arlock, arcache, arprot, arqos, arregion,
    input arvalid, rready,
    output awready, wready, bid, bresp, bvalid, arready, rid, rdata, rresp, rlast, rvalid
  );
endinterface
`default_nettype wire

// ### include/axcf_pkg.sv
// Package with AXI4 link constants, encodings and the WID queue depth.
package axcf_pkg;
  localparam int ID_W = 4;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int LEN_W = 8;
  localparam int QD = 4;
  localparam int QP_W = 2;
  localparam int MEM_W = 4;
  localparam logic [LEN_W-1:0] LEN_DEF = 8'h00;
  localparam logic [2:0] SIZE_DEF = 3'h2;
  localparam logic [1:0] BURST_INCR = 2'h1;
  localparam logic [1:0] BURST_FIXED = 2'h0;
  localparam logic [1:0] BURST_WRAP = 2'h2;
  localparam logic LOCK_NORMAL = 1'h0;
  localparam logic [3:0] CACHE_DEF = 4'h0;
  localparam logic [3:0] QOS_DEF = 4'h0;
  localparam logic [3:0] REGION_DEF = 4'h0;
  localparam logic [STRB_W-1:0] STRB_ALL = 4'hf;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [MEM_W-1:0] WORD_IDX_LSB = 4'h2;
endpackage

// ### rtl/axcf_master.sv
// Master end of the AXI4 link issuing single bursts from a user command port.
`timescale 1ns/100ps
`default_nettype none
module axcf_master
  import axcf_pkg::*;
(
  // Link
  axcf_if.mst BUS,
  // User command
  input wire logic CMD_VALID,
  input wire logic CMD_WRITE,
  input wire logic [ID_W-1:0] CMD_ID,
  input wire logic [ADDR_W-1:0] CMD_ADDR,
  input wire logic [LEN_W-1:0] CMD_LEN,
  input wire logic [DATA_W-1:0] CMD_WDATA,
  output logic CMD_READY,
  // User result
  output logic RES_VALID,
  output logic [DATA_W-1:0] RES_DATA,
  output logic [1:0] RES_RESP
);
  typedef enum logic [3:0] {
    AXCF_M_IDLE = 4'b0001,
    AXCF_M_ADDR = 4'b0010,
    AXCF_M_DATA = 4'b0100,
    AXCF_M_WAIT = 4'b1000
  } axcf_ms_t;

  typedef struct packed {
    axcf_ms_t ms;
    logic wr;
    logic [ID_W-1:0] id;
    logic [ADDR_W-1:0] addr;
    logic [LEN_W-1:0] len;
    logic [LEN_W-1:0] beats;
    logic [DATA_W-1:0] wdata;
    logic awvalid;
    logic arvalid;
    logic wvalid;
    logic wlast;
    logic bready;
    logic rready;
    logic ready;
    logic res_valid;
    logic [DATA_W-1:0] res_data;
    logic [1:0] res_resp;
  } axcf_mst_t;

  axcf_mst_t st_r;
  axcf_mst_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.res_valid = 1'b0;
    unique case (st_r.ms)
      AXCF_M_IDLE: begin
        st_nxt.ready = 1'b1;
        if (CMD_VALID && st_r.ready) begin
          st_nxt.ready = 1'b0;
          st_nxt.wr = CMD_WRITE;
          st_nxt.id = CMD_ID;
          st_nxt.addr = CMD_ADDR;
          st_nxt.len = CMD_LEN;
          st_nxt.beats = CMD_LEN;
          st_nxt.wdata = CMD_WDATA;
          st_nxt.awvalid = CMD_WRITE;
          st_nxt.arvalid = !CMD_WRITE;
          st_nxt.ms = AXCF_M_ADDR;
        end
      end
      AXCF_M_ADDR: begin
        if (st_r.awvalid && BUS.awready) begin
          st_nxt.awvalid = 1'b0;
          st_nxt.wvalid = 1'b1;
          st_nxt.wlast = (st_r.len == LEN_DEF);
          st_nxt.ms = AXCF_M_DATA;
        end
        if (st_r.arvalid && BUS.arready) begin
          st_nxt.arvalid = 1'b0;
          st_nxt.ms = AXCF_M_WAIT;
        end
      end
      AXCF_M_DATA: begin
        // Data only after its own address, beats unbroken.
        if (BUS.wready) begin
          st_nxt.wdata = st_r.wdata + DATA_W'(1);
          st_nxt.beats = st_r.beats - LEN_W'(1);
          st_nxt.wlast = (st_nxt.beats == LEN_DEF);
          if (st_r.beats == LEN_DEF) begin
            st_nxt.wvalid = 1'b0;
            st_nxt.ms = AXCF_M_WAIT;
          end
        end
      end
      AXCF_M_WAIT: begin
        // Ready rises a cycle after the channel opens, so the slave must hold its answer.
        st_nxt.bready = st_r.wr;
        st_nxt.rready = !st_r.wr;
        if (st_r.bready && BUS.bvalid) begin
          st_nxt.bready = 1'b0;
          st_nxt.res_valid = 1'b1;
          st_nxt.res_resp = BUS.bresp;
          st_nxt.res_data = '0;
          st_nxt.ready = 1'b1;
          st_nxt.ms = AXCF_M_IDLE;
        end
        if (st_r.rready && BUS.rvalid) begin
          st_nxt.res_valid = 1'b1;
          st_nxt.res_data = BUS.rdata;
          st_nxt.res_resp = BUS.rresp;
          if (BUS.rlast) begin
            st_nxt.rready = 1'b0;
            st_nxt.ready = 1'b1;
            st_nxt.ms = AXCF_M_IDLE;
          end
        end
      end
      default: begin
        st_nxt.ms = AXCF_M_IDLE;
      end
    endcase
  end

  always_ff @(posedge BUS.SYS_CLK or negedge BUS.RSTN) begin
    if (!BUS.RSTN) begin
      st_r <= '0;
      st_r.ms <= AXCF_M_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Optional outputs that this master never varies sit at their defaults.
  assign BUS.awid = st_r.id;
  assign BUS.awaddr = st_r.addr;
  assign BUS.awlen = st_r.len;
  assign BUS.awsize = SIZE_DEF;
  assign BUS.awburst = BURST_INCR;
  assign BUS.awlock = LOCK_NORMAL;
  assign BUS.awcache = CACHE_DEF;
  assign BUS.awprot = 3'h0;
  assign BUS.awqos = QOS_DEF;
  assign BUS.awregion = REGION_DEF;
  assign BUS.awvalid = st_r.awvalid;
  assign BUS.wdata = st_r.wdata;
  assign BUS.wstrb = STRB_ALL;
  assign BUS.wlast = st_r.wlast;
  assign BUS.wvalid = st_r.wvalid;
  assign BUS.bready = st_r.bready;
  assign BUS.arid = st_r.id;
  assign BUS.araddr = st_r.addr;
  assign BUS.arlen = st_r.len;
  assign BUS.arsize = SIZE_DEF;
  assign BUS.arburst = BURST_INCR;
  assign BUS.arlock = LOCK_NORMAL;
  assign BUS.arcache = CACHE_DEF;
  assign BUS.arprot = 3'h0;
  assign BUS.arqos = QOS_DEF;
  assign BUS.arregion = REGION_DEF;
  assign BUS.arvalid = st_r.arvalid;
  assign BUS.rready = st_r.rready;
  assign CMD_READY = st_r.ready;
  assign RES_VALID = st_r.res_valid;
  assign RES_DATA = st_r.res_data;
  assign RES_RESP = st_r.res_resp;
endmodule
`default_nettype wire

// ### rtl/axcf_slave.sv
// Memory slave end of the AXI4 link with legacy write data identifier regeneration.
`timescale 1ns/100ps
`default_nettype none

// Interface rules this block is written to
// - Master sends one burst's beats unbroken.
// - Write bursts follow write address order.
// - Write data identifier derived from address identifier.
// - Legacy interleaving masters set depth one.
// - Accept every legal input value combination.
// - Omit outputs only when always default.
// - Omit inputs only when never needed.
// - Interconnect may regenerate or drop signals.
// - Read-write port has all five channels.
// - Read-only port: two channels, no exclusives.
// - Write-only port: three channels, no exclusives.
// - Memory slave handles every transaction type.
// - Peripheral completes stray accesses without deadlock.
// - Drive optional outputs that differ from default.
// - Prefer implementing every interface signal.
module axcf_slave
  import axcf_pkg::*;
(
  // Link
  axcf_if.slv BUS,
  // Legacy write data identifier for a downstream bridge
  output logic [ID_W-1:0] LEGACY_WID,
  output logic LEGACY_WID_VALID,
  // Status
  output logic EXCL_SEEN
);
  typedef enum logic [2:0] {
    AXCF_W_IDLE = 3'b001,
    AXCF_W_DATA = 3'b010,
    AXCF_W_RESP = 3'b100
  } axcf_ws_t;

  typedef enum logic [1:0] {
    AXCF_R_IDLE = 2'b01,
    AXCF_R_DATA = 2'b10
  } axcf_rs_t;

  typedef struct packed {
    axcf_ws_t ws;
    logic [ID_W-1:0] aw_id;
    logic [ADDR_W-1:0] aw_addr;
    logic [LEN_W-1:0] aw_len;
    logic [LEN_W-1:0] aw_total;
    logic [2:0] aw_size;
    logic [1:0] aw_burst;
    logic awready;
    logic wready;
    logic bvalid;
    logic [ID_W-1:0] bid;
    logic [1:0] bresp;
    logic [QD-1:0][ID_W-1:0] q;
    logic [QP_W:0] q_cnt;
    axcf_rs_t rs;
    logic [ID_W-1:0] ar_id;
    logic [ADDR_W-1:0] ar_addr;
    logic [LEN_W-1:0] ar_len;
    logic [LEN_W-1:0] ar_total;
    logic [2:0] ar_size;
    logic [1:0] ar_burst;
    logic arready;
    logic rvalid;
    logic rlast;
    logic [DATA_W-1:0] rdata;
    logic [ID_W-1:0] rid;
    logic [ID_W-1:0] wid;
    logic wid_valid;
    logic excl;
  } axcf_st_t;

  axcf_st_t st_r;
  axcf_st_t st_nxt;
  logic [DATA_W-1:0] mem [0:(1<<MEM_W)-1];
  logic [MEM_W-1:0] wr_idx;
  logic do_write;

  // ---------------------------------------------------------------------------
  // Address arithmetic
  // ---------------------------------------------------------------------------
  // Next beat address for fixed, incrementing and wrapping bursts.
  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
      input logic [2:0] sz, input logic [1:0] bt, input logic [LEN_W-1:0] len);
    logic [ADDR_W-1:0] step;
    logic [ADDR_W-1:0] span;
    logic [ADDR_W-1:0] inc;
    step = ADDR_W'(1) << sz;
    span = step * ADDR_W'({1'b0, len} + 9'h001);
    inc = a + step;
    if (bt == BURST_FIXED) begin
      next_addr = a;
    end else if (bt == BURST_WRAP) begin
      next_addr = (a & ~(span - ADDR_W'(1))) | (inc & (span - ADDR_W'(1)));
    end else begin
      next_addr = inc;
    end
  endfunction

  function automatic logic [MEM_W-1:0] word_idx(input logic [ADDR_W-1:0] a);
    word_idx = a[WORD_IDX_LSB +: MEM_W];
  endfunction

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic aw_hs;
    logic w_hs;
    logic pop;
    logic [ID_W-1:0] head;
    aw_hs = 1'b0;
    w_hs = 1'b0;
    pop = 1'b0;
    head = st_r.q[0];
    st_nxt = st_r;
    do_write = 1'b0;
    wr_idx = word_idx(st_r.aw_addr);
    aw_hs = BUS.awvalid && st_r.awready;
    w_hs = BUS.wvalid && st_r.wready;
    st_nxt.wid_valid = 1'b0;
    // Exclusives only raise a flag and complete with OKAY, so none can deadlock.
    // Only a read-write port like this one may carry them.
    if ((aw_hs && BUS.awlock != LOCK_NORMAL) || (BUS.arvalid && st_r.arready &&
        BUS.arlock != LOCK_NORMAL)) begin
      st_nxt.excl = 1'b1;
    end
    unique case (st_r.ws)
      AXCF_W_IDLE: begin
        st_nxt.awready = 1'b1;
        if (aw_hs) begin
          st_nxt.awready = 1'b0;
          st_nxt.wready = 1'b1;
          // Cache, protection, QoS and region are not needed here, so never read.
          st_nxt.aw_id = BUS.awid;
          st_nxt.aw_addr = BUS.awaddr;
          st_nxt.aw_len = BUS.awlen;
          st_nxt.aw_total = BUS.awlen;
          st_nxt.aw_size = BUS.awsize;
          st_nxt.aw_burst = BUS.awburst;
          st_nxt.ws = AXCF_W_DATA;
        end
      end
      AXCF_W_DATA: begin
        // Beats are taken in order, one burst at a time.
        if (w_hs) begin
          do_write = 1'b1;
          st_nxt.aw_addr = next_addr(st_r.aw_addr, st_r.aw_size, st_r.aw_burst, st_r.aw_total);
          st_nxt.aw_len = st_r.aw_len - LEN_W'(1);
          // Burst end follows the length count, so a missing last flag cannot hang.
          if (st_r.aw_len == LEN_DEF) begin
            st_nxt.wready = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bid = st_r.aw_id;
            st_nxt.bresp = RESP_OKAY;
            st_nxt.wid = head;
            st_nxt.wid_valid = 1'b1;
            pop = 1'b1;
            st_nxt.ws = AXCF_W_RESP;
          end
        end
      end
      AXCF_W_RESP: begin
        if (BUS.bready) begin
          st_nxt.bvalid = 1'b0;
          st_nxt.awready = 1'b1;
          st_nxt.ws = AXCF_W_IDLE;
        end
      end
      default: begin
        st_nxt.ws = AXCF_W_IDLE;
      end
    endcase
    // Identifier queue: push on address accept, pop at last beat.
    if (pop) begin
      for (int i = 0; i < QD - 1; i++) begin
        st_nxt.q[i] = st_r.q[i+1];
      end
    end
    if (aw_hs) begin
      st_nxt.q[QP_W'(st_r.q_cnt - (pop ? 1 : 0))] = BUS.awid;
    end
    st_nxt.q_cnt = st_r.q_cnt + (QP_W+1)'(aw_hs) - (QP_W+1)'(pop);
    // Read side handles every size, length and burst type.
    unique case (st_r.rs)
      AXCF_R_IDLE: begin
        st_nxt.arready = 1'b1;
        if (BUS.arvalid && st_r.arready) begin
          st_nxt.arready = 1'b0;
          st_nxt.ar_id = BUS.arid;
          st_nxt.ar_addr = BUS.araddr;
          st_nxt.ar_len = BUS.arlen;
          st_nxt.ar_total = BUS.arlen;
          st_nxt.ar_size = BUS.arsize;
          st_nxt.ar_burst = BUS.arburst;
          st_nxt.rvalid = 1'b1;
          st_nxt.rid = BUS.arid;
          st_nxt.rdata = mem[word_idx(BUS.araddr)];
          st_nxt.rlast = (BUS.arlen == LEN_DEF);
          st_nxt.rs = AXCF_R_DATA;
        end
      end
      AXCF_R_DATA: begin
        if (BUS.rready) begin
          if (st_r.rlast) begin
            st_nxt.rvalid = 1'b0;
            st_nxt.rlast = 1'b0;
            st_nxt.arready = 1'b1;
            st_nxt.rs = AXCF_R_IDLE;
          end else begin
            st_nxt.ar_addr = next_addr(st_r.ar_addr, st_r.ar_size, st_r.ar_burst, st_r.ar_total);
            st_nxt.ar_len = st_r.ar_len - LEN_W'(1);
            st_nxt.rdata = mem[word_idx(st_nxt.ar_addr)];
            st_nxt.rlast = (st_nxt.ar_len == LEN_DEF);
          end
        end
      end
      default: begin
        st_nxt.rs = AXCF_R_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge BUS.SYS_CLK or negedge BUS.RSTN) begin
    if (!BUS.RSTN) begin
      st_r <= '0;
      st_r.ws <= AXCF_W_IDLE;
      st_r.rs <= AXCF_R_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Byte strobes steer each lane of the storage word.
  always_ff @(posedge BUS.SYS_CLK) begin
    if (do_write) begin
      for (int b = 0; b < STRB_W; b++) begin
        if (BUS.wstrb[b]) begin
          mem[wr_idx][8*b +: 8] <= BUS.wdata[8*b +: 8];
        end
      end
    end
  end

  // All five channels are driven, optional outputs too.
  assign BUS.awready = st_r.awready;
  assign BUS.wready = st_r.wready;
  assign BUS.bvalid = st_r.bvalid;
  assign BUS.bid = st_r.bid;
  assign BUS.bresp = st_r.bresp;
  assign BUS.arready = st_r.arready;
  assign BUS.rvalid = st_r.rvalid;
  assign BUS.rid = st_r.rid;
  assign BUS.rdata = st_r.rdata;
  assign BUS.rresp = RESP_OKAY;
  assign BUS.rlast = st_r.rlast;
  assign LEGACY_WID = st_r.wid;
  assign LEGACY_WID_VALID = st_r.wid_valid;
  assign EXCL_SEEN = st_r.excl;
endmodule
`default_nettype wire

// ### verification/axcf_asserts.sv
// Concurrent checks on the link that joins the master and slave ends.
`timescale 1ns/100ps
`default_nettype none
module axcf_asserts
  import axcf_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // Write channels
  input wire logic [ID_W-1:0] awid,
  input wire logic [LEN_W-1:0] awlen,
  input wire logic [2:0] awsize,
  input wire logic [1:0] awburst,
  input wire logic awlock,
  input wire logic [3:0] awqos,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [STRB_W-1:0] wstrb,
  input wire logic wlast,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [ID_W-1:0] bid,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  // Read channels
  input wire logic [ID_W-1:0] arid,
  input wire logic [LEN_W-1:0] arlen,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [ID_W-1:0] rid,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rlast,
  input wire logic rvalid,
  input wire logic rready,
  // Legacy identifier
  input wire logic [ID_W-1:0] LEGACY_WID,
  input wire logic LEGACY_WID_VALID
);
  // ----------------------------------------
  // Burst tracking
  // ----------------------------------------
  typedef struct packed {
    logic aw_open;
    logic [ID_W-1:0] w_id;
    logic [LEN_W-1:0] w_len;
    logic [LEN_W-1:0] w_beat;
    logic [ID_W-1:0] r_id;
    logic [LEN_W-1:0] r_len;
    logic [LEN_W-1:0] r_beat;
  } axcf_trk_t;
  axcf_trk_t trk_r;
  axcf_trk_t trk_nxt;

  always_comb begin
    trk_nxt = trk_r;
    if (awvalid && awready) begin
      trk_nxt.aw_open = 1'b1;
      trk_nxt.w_id = awid;
      trk_nxt.w_len = awlen;
      trk_nxt.w_beat = 8'h00;
    end
    if (wvalid && wready) begin
      trk_nxt.w_beat = trk_r.w_beat + 8'h01;
      if (wlast) begin
        trk_nxt.aw_open = 1'b0;
      end
    end
    if (arvalid && arready) begin
      trk_nxt.r_id = arid;
      trk_nxt.r_len = arlen;
      trk_nxt.r_beat = 8'h00;
    end
    if (rvalid && rready) begin
      trk_nxt.r_beat = trk_r.r_beat + 8'h01;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      trk_r <= '0;
    end else begin
      trk_r <= trk_nxt;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);

  a_wlast_at_count: assert property (wvalid |->
    wlast == (trk_r.w_beat == trk_r.w_len))
    else $error("write last beat not at burst length");
  a_w_after_aw: assert property (wvalid && wready |-> trk_r.aw_open)
    else $error("write beat without open write address");
  a_wid_from_aw: assert property (wvalid && wready && wlast |=>
    LEGACY_WID_VALID && LEGACY_WID == trk_r.w_id)
    else $error("legacy identifier wrong or late");
  a_b_after_last: assert property (wvalid && wready && wlast |=>
    bvalid && bid == trk_r.w_id && bresp == RESP_OKAY)
    else $error("write response wrong or late");
  a_b_holds: assert property (bvalid && !bready |=> bvalid && $stable(bid))
    else $error("write response dropped before accepted");
  a_r_first: assert property (arvalid && arready |=> rvalid && rid == $past(arid))
    else $error("read data not answered one cycle after address");
  a_rlast_count: assert property (rvalid |->
    rlast == (trk_r.r_beat == trk_r.r_len) && rresp == RESP_OKAY && rid == trk_r.r_id)
    else $error("read last beat or response wrong");
  a_r_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before accepted");
  a_aw_defaults: assert property (awvalid |-> awburst == BURST_INCR
    && awsize == SIZE_DEF && awlock == LOCK_NORMAL && awqos == QOS_DEF)
    else $error("write address field not at default");
  a_w_strobes: assert property (wvalid |-> wstrb == STRB_ALL)
    else $error("write strobes not all set");
endmodule
`default_nettype wire

// ### verification/test_axi4_interface_conformance.sv
// Self-checking bench joining the master and slave ends over one link.
`timescale 1ns/100ps
`default_nettype none
module test_axi4_interface_conformance;
  import axcf_pkg::*;
  logic sys_clk;
  logic rstn;
  logic cmd_valid;
  logic cmd_write;
  logic [ID_W-1:0] cmd_id;
  logic [ADDR_W-1:0] cmd_addr;
  logic [LEN_W-1:0] cmd_len;
  logic [DATA_W-1:0] cmd_wdata;
  logic cmd_ready;
  logic res_valid;
  logic [DATA_W-1:0] res_data;
  logic [1:0] res_resp;
  logic [ID_W-1:0] legacy_wid;
  logic legacy_wid_valid;
  logic excl_seen;
  logic [DATA_W-1:0] mdl [16];
  logic [DATA_W+1:0] res_q [$];
  logic [ID_W-1:0] wid_q [$];
  logic [31:0] r1;
  logic [31:0] r2;
  integer seed = 32'ha73f17b8;
  int mismatches = 0;
  int num_checks = 0;

  // ----------------------------------------
  // Design and checker
  // ----------------------------------------
  axcf_if bus (.SYS_CLK(sys_clk), .RSTN(rstn));
  axcf_master axcf_master_inst (.BUS(bus.mst), .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write),
    .CMD_ID(cmd_id), .CMD_ADDR(cmd_addr), .CMD_LEN(cmd_len), .CMD_WDATA(cmd_wdata),
    .CMD_READY(cmd_ready), .RES_VALID(res_valid), .RES_DATA(res_data), .RES_RESP(res_resp));
  axcf_slave axcf_slave_inst (.BUS(bus.slv), .LEGACY_WID(legacy_wid),
    .LEGACY_WID_VALID(legacy_wid_valid), .EXCL_SEEN(excl_seen));
  axcf_asserts axcf_asserts_inst (.SYS_CLK(sys_clk), .RSTN(rstn), .awid(bus.awid),
    .awlen(bus.awlen), .awsize(bus.awsize), .awburst(bus.awburst), .awlock(bus.awlock),
    .awqos(bus.awqos), .awvalid(bus.awvalid), .awready(bus.awready), .wstrb(bus.wstrb),
    .wlast(bus.wlast), .wvalid(bus.wvalid), .wready(bus.wready), .bid(bus.bid),
    .bresp(bus.bresp), .bvalid(bus.bvalid), .bready(bus.bready), .arid(bus.arid),
    .arlen(bus.arlen), .arvalid(bus.arvalid), .arready(bus.arready), .rid(bus.rid),
    .rdata(bus.rdata), .rresp(bus.rresp), .rlast(bus.rlast), .rvalid(bus.rvalid),
    .rready(bus.rready), .LEGACY_WID(legacy_wid), .LEGACY_WID_VALID(legacy_wid_valid));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Results are one-cycle pulses, so they are collected at every falling edge.
  always @(negedge sys_clk) begin
    if (res_valid === 1'b1) res_q.push_back({res_resp, res_data});
    if (legacy_wid_valid === 1'b1) wid_q.push_back(legacy_wid);
  end

  // ----------------------------------------
  // Compare tasks and run control
  // ----------------------------------------
  task chk_data(input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch data at %0t: exp %h got %h", $time, exp, got);
    end
  endtask

  task chk_resp(input logic [1:0] exp, input logic [1:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch resp at %0t: exp %h got %h", $time, exp, got);
    end
  endtask

  task chk_id(input logic [ID_W-1:0] exp, input logic [ID_W-1:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch id at %0t: exp %h got %h", $time, exp, got);
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Word of the model that beat i of an incrementing burst lands in.
  function automatic logic [3:0] exp_idx(input logic [ADDR_W-1:0] a, input int i);
    exp_idx = a[5:2] + i[3:0];
  endfunction

  // One command, then every result it yields is checked, read data against the memory model.
  task run_cmd(input logic wr, input logic [ID_W-1:0] id, input logic [ADDR_W-1:0] addr,
               input logic [LEN_W-1:0] len, input logic [DATA_W-1:0] data);
    int n;
    int k;
    logic [DATA_W+1:0] res;
    n = 0;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_id = id;
    cmd_addr = addr;
    cmd_len = len;
    cmd_wdata = data;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    k = wr ? 1 : int'(len) + 1;
    n = 0;
    while (res_q.size() < k && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    chk_data(DATA_W'(k), DATA_W'(res_q.size()));
    for (int i = 0; i < k && res_q.size() > 0; i++) begin
      res = res_q.pop_front();
      chk_resp(RESP_OKAY, res[DATA_W+1:DATA_W]);
      if (!wr) chk_data(mdl[exp_idx(addr, i)], res[DATA_W-1:0]);
    end
    if (wr) begin
      chk_data('0, res[DATA_W-1:0]);
      chk_id(id, (wid_q.size() != 0) ? wid_q.pop_front() : 'x);
      for (int i = 0; i <= int'(len); i++) begin
        mdl[exp_idx(addr, i)] = data + DATA_W'(i);
      end
    end
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_id = '0;
    cmd_addr = '0;
    cmd_len = '0;
    cmd_wdata = '0;
    rstn = 1'b0;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    rstn = 1'b1;
    repeat (2) @(negedge sys_clk);
    run_cmd(1'b1, 4'h3, 32'h0000_0000, 8'h0f, $random(seed));
    run_cmd(1'b0, 4'h3, 32'h0000_0000, 8'h0f, 32'h0000_0000);
    run_cmd(1'b1, 4'hf, 32'h0000_003c, 8'h00, $random(seed));
    run_cmd(1'b0, 4'h0, 32'h0000_003c, 8'h00, 32'h0000_0000);
    run_cmd(1'b1, 4'h9, 32'h0000_0010, 8'hff, $random(seed));
    run_cmd(1'b0, 4'h9, 32'h0000_0010, 8'hff, 32'h0000_0000);
    for (int t = 0; t < 20; t++) begin
      r1 = $random(seed);
      r2 = $random(seed);
      run_cmd(r1[0], r1[7:4], {r2[31:2], 2'b00}, {3'b000, r1[12:8]}, r2);
    end
    chk_resp(2'h0, {1'b0, excl_seen});
    test_done;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    $display("mismatch timeout at %0t: exp %h got %h", $time, 0, 1);
    test_done;
  end
endmodule
`default_nettype wire
